/* File: verilog/mid_decoder.sv */
// Instruction decode and execution control for the 8-bit core
//
// Contract
// - Add with carry sums accumulator, file byte and carry; updates C, DC, Z.
// - Subtract with borrow takes accumulator and borrow from file byte; C, DC, Z.
// - Rotates shift the file byte through carry and change only carry.
// - Decrement/increment skip write the byte, skip on zero, leave flags alone.
// - Bit tests skip on clear (10) or set (11), three-bit bit select.
// - Literal load of the upper PC latch takes seven bits, no flag change.
// - Literal OR into the accumulator updates only zero.
// - Accumulator XOR file byte, steered by destination, updates only zero.
// - PC change or true test takes two cycles, second one a no-operation.
// - Indirect port access with pointer MSB set costs one extra cycle; indirect stores take none.
// - Indirect ports hold nothing; access goes to the pointer's address.
// - Pointers are sixteen bits and wrap at both ends.
// - Pointer increment or decrement in an indirect store leaves flags alone.
// - Indirect store picks pointer and mode 00/01/10/11, or offset -32..31.
// - Indirect store writes accumulator; pre before, post after, offset unchanged.
// - Option load copies accumulator to option register in one cycle.
// - Software reset resets the device and clears the reset indicator.
`timescale 1ns/1ps
`default_nettype none
module mid_decoder #(
  parameter int PTR_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Instruction stream from fetch
  input wire logic instr_valid_i,
  input wire logic [13:0] instr_i,
  output logic instr_ready_o,
  // Program counter control
  output logic pc_load_o,
  output logic [10:0] pc_target_o,
  output logic skip_o,
  output logic [6:0] upper_pc_latch_o,
  // Core state
  output logic [7:0] acc_o,
  output mid_pkg::mid_status_t status_o,
  output logic [7:0] option_o,
  output logic [PTR_W-1:0] ptr0_o,
  output logic [PTR_W-1:0] ptr1_o,
  // Reset control
  output logic sw_reset_o,
  output logic reset_instruction_indicator_o
);
  typedef enum logic [1:0] {
    MID_IDLE = 2'b00,
    MID_EXEC = 2'b01,
    MID_EXTRA = 2'b10,
    MID_NOP = 2'b11
  } mid_state_t;

  mid_state_t state_reg, state_next;
  logic [13:0] ir_reg;
  logic [6:0] ea_reg;
  logic ind_slow_reg;
  logic [7:0] fdat;
  logic [6:0] rd_addr;
  logic [1:0] cls;
  logic [3:0] op;
  logic dst;
  logic [7:0] k8;
  logic [2:0] bsel;
  mid_pkg::mid_wr_t wr;
  // Result of the execute stage
  logic [7:0] res;
  logic wr_acc, wr_file, skip, branch, do_reset, do_option, do_pclatch;
  mid_pkg::mid_status_t st_n;
  logic ind_store, ptr_sel;
  logic [PTR_W-1:0] ptr_cur, ptr_new, ptr_addr;
  logic [8:0] sum9;
  logic [4:0] sum5;

  assign cls = ir_reg[13:12];
  assign op = ir_reg[11:8];
  assign dst = ir_reg[7];
  assign k8 = ir_reg[7:0];
  assign bsel = ir_reg[9:7];

  // Instruction that takes a file operand, indirect port applies
  function automatic logic takes_file(input logic [13:0] w);
    logic [3:0] o;
    o = w[11:8];
    case (w[13:12])
      mid_pkg::CLS_BYTE: takes_file = (o != mid_pkg::OP_MOVWF) || w[7];
      mid_pkg::CLS_BIT: takes_file = 1'b1;
      mid_pkg::CLS_LIT: takes_file = (o == mid_pkg::OP_ADD_CARRY_FILE) ||
        (o == mid_pkg::OP_SUB_BORROW_FILE) || (o == mid_pkg::OP_LSLF) ||
        (o == mid_pkg::OP_LSRF) || (o == mid_pkg::OP_ASRF);
      default: takes_file = 1'b0;
    endcase
  endfunction

  // Indirect ports redirect to the pointer's address, no storage behind them
  always_comb begin
    rd_addr = instr_i[6:0];
    if (takes_file(instr_i) && instr_i[6:0] == mid_pkg::ADDR_IND_PORT0) begin
      rd_addr = ptr0_o[6:0];
    end else if (takes_file(instr_i) && instr_i[6:0] == mid_pkg::ADDR_IND_PORT1) begin
      rd_addr = ptr1_o[6:0];
    end
  end

  mid_file_ram #(
    .AW(7),
    .DW(8)
  ) u_ram (
    .clk_i(clk_i),
    .rd_addr_i(rd_addr),
    .rd_data_o(fdat),
    .wr_en_i(wr.en),
    .wr_addr_i(wr.addr),
    .wr_data_i(wr.data)
  );

  // Latch the word and its effective address on acceptance
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ir_reg <= 14'h0000;
      ea_reg <= 7'h00;
      ind_slow_reg <= 1'b0;
    end else if (state_reg == MID_IDLE && instr_valid_i) begin
      ir_reg <= instr_i;
      ea_reg <= rd_addr;
      ind_slow_reg <= takes_file(instr_i) &&
        ((instr_i[6:0] == mid_pkg::ADDR_IND_PORT0 && ptr0_o[PTR_W-1]) ||
         (instr_i[6:0] == mid_pkg::ADDR_IND_PORT1 && ptr1_o[PTR_W-1]));
    end
  end

  // Indirect store: pointer select, mode, relative offset
  always_comb begin
    ptr_sel = ir_reg[2];
    ind_store = 1'b0;
    if (cls == mid_pkg::CLS_BYTE && ir_reg[11:3] == {4'h0, mid_pkg::IND_STORE_PREFIX}) begin
      ind_store = 1'b1;
    end else if (cls == mid_pkg::CLS_LIT && op == mid_pkg::OP_IND_STORE_REL && dst) begin
      ind_store = 1'b1;
      ptr_sel = ir_reg[6];
    end
    ptr_cur = ptr_sel ? ptr1_o : ptr0_o;
    ptr_new = ptr_cur;
    ptr_addr = ptr_cur;
    if (cls == mid_pkg::CLS_LIT) begin
      ptr_addr = ptr_cur + {{(PTR_W-6){ir_reg[5]}}, ir_reg[5:0]};
    end else begin
      case (ir_reg[1:0])
        mid_pkg::PTR_PRE_INC: begin
          ptr_new = ptr_cur + 1'b1;
          ptr_addr = ptr_new;
        end
        mid_pkg::PTR_PRE_DEC: begin
          ptr_new = ptr_cur - 1'b1;
          ptr_addr = ptr_new;
        end
        mid_pkg::PTR_POST_INC: ptr_new = ptr_cur + 1'b1;
        default: ptr_new = ptr_cur - 1'b1;
      endcase
    end
  end

  // Execute: result, flags, destination, skip and branch
  always_comb begin
    res = fdat;
    st_n = status_o;
    wr_acc = 1'b0;
    wr_file = 1'b0;
    skip = 1'b0;
    branch = 1'b0;
    do_reset = 1'b0;
    do_option = 1'b0;
    do_pclatch = 1'b0;
    sum9 = 9'h000;
    sum5 = 5'h00;
    case (cls)
      mid_pkg::CLS_BYTE: begin
        wr_acc = !dst;
        wr_file = dst;
        case (op)
          mid_pkg::OP_MOVWF: begin
            wr_acc = 1'b0;
            wr_file = dst;
            res = acc_o;
            do_reset = (ir_reg == mid_pkg::WORD_SW_RESET);
            do_option = (ir_reg == mid_pkg::WORD_OPTION_LOAD);
          end
          mid_pkg::OP_CLR: begin
            res = 8'h00;
            st_n.z = 1'b1;
          end
          mid_pkg::OP_SUBWF, mid_pkg::OP_ADDWF: begin
            sum9 = (op == mid_pkg::OP_ADDWF) ? {1'b0, fdat} + {1'b0, acc_o}
              : {1'b0, fdat} + {1'b0, ~acc_o} + 9'h001;
            sum5 = (op == mid_pkg::OP_ADDWF) ? {1'b0, fdat[3:0]} + {1'b0, acc_o[3:0]}
              : {1'b0, fdat[3:0]} + {1'b0, ~acc_o[3:0]} + 5'h01;
            res = sum9[7:0];
            st_n = '{z: (sum9[7:0] == 8'h00), dc: sum5[4], c: sum9[8]};
          end
          mid_pkg::OP_DECF, mid_pkg::OP_INCF: begin
            res = (op == mid_pkg::OP_INCF) ? fdat + 8'h01 : fdat - 8'h01;
            st_n.z = (res == 8'h00);
          end
          mid_pkg::OP_IORWF, mid_pkg::OP_ANDWF, mid_pkg::OP_XOR_ACC_FILE: begin
            res = (op == mid_pkg::OP_IORWF) ? (fdat | acc_o)
              : (op == mid_pkg::OP_ANDWF) ? (fdat & acc_o) : (fdat ^ acc_o);
            st_n.z = (res == 8'h00);
          end
          mid_pkg::OP_MOVF, mid_pkg::OP_COMF: begin
            res = (op == mid_pkg::OP_COMF) ? ~fdat : fdat;
            st_n.z = (res == 8'h00);
          end
          mid_pkg::OP_DEC_SKIP_ZERO, mid_pkg::OP_INC_SKIP_ZERO: begin
            res = (op == mid_pkg::OP_INC_SKIP_ZERO) ? fdat + 8'h01 : fdat - 8'h01;
            skip = (res == 8'h00);
          end
          mid_pkg::OP_ROT_RIGHT: begin
            res = {status_o.c, fdat[7:1]};
            st_n.c = fdat[0];
          end
          mid_pkg::OP_ROT_LEFT: begin
            res = {fdat[6:0], status_o.c};
            st_n.c = fdat[7];
          end
          default: res = {fdat[3:0], fdat[7:4]};
        endcase
        if (ind_store) begin
          wr_acc = 1'b0;
          wr_file = 1'b0;
        end
      end
      mid_pkg::CLS_BIT: begin
        res = fdat;
        case (ir_reg[11:10])
          mid_pkg::BIT_CLEAR: begin
            res[bsel] = 1'b0;
            wr_file = 1'b1;
          end
          mid_pkg::BIT_SET: begin
            res[bsel] = 1'b1;
            wr_file = 1'b1;
          end
          mid_pkg::BIT_TEST_SKIP_CLEAR: skip = !fdat[bsel];
          default: skip = fdat[bsel];
        endcase
      end
      mid_pkg::CLS_BRANCH: branch = 1'b1;
      default: begin
        wr_acc = 1'b1;
        case (op)
          mid_pkg::OP_MOVLW: res = k8;
          mid_pkg::OP_LOAD_PC_LATCH: begin
            wr_acc = 1'b0;
            do_pclatch = dst;
          end
          mid_pkg::OP_ADD_CARRY_FILE, mid_pkg::OP_SUB_BORROW_FILE, mid_pkg::OP_ADDLW,
          mid_pkg::OP_SUBLW: begin
            wr_acc = !dst || op == mid_pkg::OP_ADDLW || op == mid_pkg::OP_SUBLW;
            wr_file = dst && !(op == mid_pkg::OP_ADDLW || op == mid_pkg::OP_SUBLW);
            case (op)
              mid_pkg::OP_ADD_CARRY_FILE: begin
                sum9 = {1'b0, fdat} + {1'b0, acc_o} + {8'h00, status_o.c};
                sum5 = {1'b0, fdat[3:0]} + {1'b0, acc_o[3:0]} + {4'h0, status_o.c};
              end
              mid_pkg::OP_SUB_BORROW_FILE: begin
                sum9 = {1'b0, fdat} + {1'b0, ~acc_o} + {8'h00, status_o.c};
                sum5 = {1'b0, fdat[3:0]} + {1'b0, ~acc_o[3:0]} + {4'h0, status_o.c};
              end
              mid_pkg::OP_ADDLW: begin
                sum9 = {1'b0, k8} + {1'b0, acc_o};
                sum5 = {1'b0, k8[3:0]} + {1'b0, acc_o[3:0]};
              end
              default: begin
                sum9 = {1'b0, k8} + {1'b0, ~acc_o} + 9'h001;
                sum5 = {1'b0, k8[3:0]} + {1'b0, ~acc_o[3:0]} + 5'h01;
              end
            endcase
            res = sum9[7:0];
            st_n = '{z: (sum9[7:0] == 8'h00), dc: sum5[4], c: sum9[8]};
          end
          mid_pkg::OP_LSLF, mid_pkg::OP_LSRF, mid_pkg::OP_ASRF: begin
            wr_acc = !dst;
            wr_file = dst;
            res = (op == mid_pkg::OP_LSLF) ? {fdat[6:0], 1'b0}
              : {(op == mid_pkg::OP_ASRF) & fdat[7], fdat[7:1]};
            st_n.c = (op == mid_pkg::OP_LSLF) ? fdat[7] : fdat[0];
            st_n.z = (res == 8'h00);
          end
          mid_pkg::OP_OR_LIT_ACC, mid_pkg::OP_ANDLW, mid_pkg::OP_XORLW: begin
            res = (op == mid_pkg::OP_OR_LIT_ACC) ? (acc_o | k8)
              : (op == mid_pkg::OP_ANDLW) ? (acc_o & k8) : (acc_o ^ k8);
            st_n.z = (res == 8'h00);
          end
          default: wr_acc = 1'b0;
        endcase
      end
    endcase
  end

  // File write port: ordinary results or the indirect store
  always_comb begin
    wr = '0;
    if (state_reg == MID_EXEC) begin
      if (ind_store) begin
        wr = '{en: 1'b1, addr: ptr_addr[6:0], data: acc_o};
      end else if (wr_file) begin
        wr = '{en: 1'b1, addr: ea_reg, data: res};
      end
    end
  end

  // Sequencer: execute, extra indirect cycle, then no-operation cycle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MID_IDLE: if (instr_valid_i) state_next = MID_EXEC;
      MID_EXEC: begin
        if (do_reset) begin
          state_next = MID_IDLE;
        end else if (ind_slow_reg) begin
          state_next = MID_EXTRA;
        end else if (skip || branch) begin
          state_next = MID_NOP;
        end else begin
          state_next = MID_IDLE;
        end
      end
      MID_EXTRA: state_next = skip_o || pc_load_o ? MID_NOP : MID_IDLE;
      default: state_next = MID_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= MID_IDLE;
      instr_ready_o <= 1'b1;
    end else begin
      state_reg <= state_next;
      instr_ready_o <= (state_next == MID_IDLE);
    end
  end

  // Program counter requests, held through the extra cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pc_load_o <= 1'b0;
      skip_o <= 1'b0;
      pc_target_o <= 11'h000;
    end else if (state_reg == MID_EXEC) begin
      pc_load_o <= branch;
      skip_o <= skip;
      pc_target_o <= ir_reg[10:0];
    end else if (state_reg != MID_EXTRA) begin
      pc_load_o <= 1'b0;
      skip_o <= 1'b0;
    end
  end

  // Architectural registers; software reset restores them like a device reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      acc_o <= 8'h00;
      status_o <= '0;
      option_o <= mid_pkg::OPTION_RESET;
      upper_pc_latch_o <= 7'h00;
      ptr0_o <= mid_pkg::PTR_RESET;
      ptr1_o <= mid_pkg::PTR_RESET;
    end else if (state_reg == MID_EXEC && do_reset) begin
      acc_o <= 8'h00;
      status_o <= '0;
      option_o <= mid_pkg::OPTION_RESET;
      upper_pc_latch_o <= 7'h00;
      ptr0_o <= mid_pkg::PTR_RESET;
      ptr1_o <= mid_pkg::PTR_RESET;
    end else if (state_reg == MID_EXEC) begin
      if (wr_acc) acc_o <= res;
      if (!ind_store) status_o <= st_n;
      if (do_option) option_o <= acc_o;
      if (do_pclatch) upper_pc_latch_o <= ir_reg[6:0];
      if (ind_store && !ptr_sel) ptr0_o <= ptr_new;
      if (ind_store && ptr_sel) ptr1_o <= ptr_new;
    end
  end

  // Reset cause: set by pin reset, cleared only by the reset instruction
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reset_instruction_indicator_o <= 1'b1;
      sw_reset_o <= 1'b0;
    end else begin
      sw_reset_o <= (state_reg == MID_EXEC) && do_reset;
      if (state_reg == MID_EXEC && do_reset) reset_instruction_indicator_o <= 1'b0;
    end
  end

  property p_skip_two_cycles;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == MID_EXEC && skip && !ind_slow_reg) |=> state_reg == MID_NOP ##1 instr_ready_o;
  endproperty
  a_skip_two_cycles: assert property (p_skip_two_cycles) else $error("skip lacks nop cycle");

  property p_extra_cycle;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == MID_EXEC && ind_slow_reg && !do_reset) |=> state_reg == MID_EXTRA;
  endproperty
  a_extra_cycle: assert property (p_extra_cycle) else $error("missing extra cycle");

  property p_ptr_flags;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == MID_EXEC && ind_store) |=> $stable(status_o);
  endproperty
  a_ptr_flags: assert property (p_ptr_flags) else $error("store changed flags");

  property p_ptr_wrap;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == MID_EXEC && ind_store && !ptr_sel && cls == mid_pkg::CLS_BYTE
       && (ir_reg[1:0] == mid_pkg::PTR_PRE_INC || ir_reg[1:0] == mid_pkg::PTR_POST_INC)
       && ptr0_o == '1) |=> ptr0_o == '0;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");

  property p_option_load;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == MID_EXEC && ir_reg == mid_pkg::WORD_OPTION_LOAD)
      |=> option_o == $past(acc_o) && $stable(status_o) && instr_ready_o;
  endproperty
  a_option_load: assert property (p_option_load) else $error("option load wrong");

  property p_sw_reset;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == MID_EXEC && ir_reg == mid_pkg::WORD_SW_RESET)
      |=> sw_reset_o && !reset_instruction_indicator_o && acc_o == 8'h00;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset wrong");

  property p_pclatch;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == MID_EXEC && cls == mid_pkg::CLS_LIT && op == mid_pkg::OP_LOAD_PC_LATCH && dst)
      |=> upper_pc_latch_o == $past(ir_reg[6:0]) && $stable(status_o);
  endproperty
  a_pclatch: assert property (p_pclatch) else $error("pc latch load wrong");

  property p_rotate_carry;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == MID_EXEC && cls == mid_pkg::CLS_BYTE && op == mid_pkg::OP_ROT_LEFT)
      |=> status_o.c == $past(fdat[7]) && status_o.z == $past(status_o.z);
  endproperty
  a_rotate_carry: assert property (p_rotate_carry) else $error("rotate flags wrong");

  property p_skip_no_flags;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == MID_EXEC && cls == mid_pkg::CLS_BYTE && op == mid_pkg::OP_INC_SKIP_ZERO)
      |=> $stable(status_o) && skip_o == ($past(fdat) == 8'hFF);
  endproperty
  a_skip_no_flags: assert property (p_skip_no_flags) else $error("inc skip wrong");
endmodule
`default_nettype wire

/* File: pkg/mid_pkg.sv */
// Shared constants and carriers for the instruction decoder
package mid_pkg;
  // Instruction classes, top two bits of the word
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_BRANCH = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  // Byte class opcodes
  localparam logic [3:0] OP_MOVWF = 4'h0;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_SUBWF = 4'h2;
  localparam logic [3:0] OP_DECF = 4'h3;
  localparam logic [3:0] OP_IORWF = 4'h4;
  localparam logic [3:0] OP_ANDWF = 4'h5;
  localparam logic [3:0] OP_XOR_ACC_FILE = 4'h6;
  localparam logic [3:0] OP_ADDWF = 4'h7;
  localparam logic [3:0] OP_MOVF = 4'h8;
  localparam logic [3:0] OP_COMF = 4'h9;
  localparam logic [3:0] OP_INCF = 4'hA;
  localparam logic [3:0] OP_DEC_SKIP_ZERO = 4'hB;
  localparam logic [3:0] OP_ROT_RIGHT = 4'hC;
  localparam logic [3:0] OP_ROT_LEFT = 4'hD;
  localparam logic [3:0] OP_SWAPF = 4'hE;
  localparam logic [3:0] OP_INC_SKIP_ZERO = 4'hF;
  // Literal class opcodes
  localparam logic [3:0] OP_MOVLW = 4'h0;
  localparam logic [3:0] OP_LOAD_PC_LATCH = 4'h1;
  localparam logic [3:0] OP_LSLF = 4'h5;
  localparam logic [3:0] OP_LSRF = 4'h6;
  localparam logic [3:0] OP_ASRF = 4'h7;
  localparam logic [3:0] OP_OR_LIT_ACC = 4'h8;
  localparam logic [3:0] OP_ANDLW = 4'h9;
  localparam logic [3:0] OP_XORLW = 4'hA;
  localparam logic [3:0] OP_SUB_BORROW_FILE = 4'hB;
  localparam logic [3:0] OP_SUBLW = 4'hC;
  localparam logic [3:0] OP_ADD_CARRY_FILE = 4'hD;
  localparam logic [3:0] OP_ADDLW = 4'hE;
  localparam logic [3:0] OP_IND_STORE_REL = 4'hF;
  // Bit class sub-codes
  localparam logic [1:0] BIT_CLEAR = 2'h0;
  localparam logic [1:0] BIT_SET = 2'h1;
  localparam logic [1:0] BIT_TEST_SKIP_CLEAR = 2'h2;
  localparam logic [1:0] BIT_TEST_SKIP_SET = 2'h3;
  // Whole-word control instructions and the indirect store prefix
  localparam logic [13:0] WORD_SW_RESET = 14'h0001;
  localparam logic [13:0] WORD_OPTION_LOAD = 14'h0062;
  localparam logic [4:0] IND_STORE_PREFIX = 5'h03;
  // Pointer update modes
  localparam logic [1:0] PTR_PRE_INC = 2'h0;
  localparam logic [1:0] PTR_PRE_DEC = 2'h1;
  localparam logic [1:0] PTR_POST_INC = 2'h2;
  localparam logic [1:0] PTR_POST_DEC = 2'h3;
  // Indirect access port file addresses
  localparam logic [6:0] ADDR_IND_PORT0 = 7'h00;
  localparam logic [6:0] ADDR_IND_PORT1 = 7'h01;
  // Reset values
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  // Status flags carried together
  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } mid_status_t;
  // One write into the file memory
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } mid_wr_t;
endpackage

/* File: verilog/mid_file_ram.sv */
// File register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module mid_file_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // Clock
  input wire logic clk_i,
  // Read port
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o,
  // Write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Read before write, read data registered one cycle later
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rd_data_o <= mem[rd_addr_i];
  end
endmodule
`default_nettype wire

/* File: tb/mid_fetch_model.sv */
// Fetch unit model that offers instruction words to the decoder
`timescale 1ns/1ps
`default_nettype none
module mid_fetch_model (
  // Clock
  input wire logic clk_i,
  // Decoder handshake
  input wire logic ready_i,
  output logic valid_o,
  output logic [13:0] word_o
);
  // Idle until the first offer
  initial begin
    valid_o = 1'b0;
    word_o = 14'h0000;
  end
  // Offer a word until taken, then count edges until the decoder is idle again
  task automatic issue(input logic [13:0] w, output int n);
    @(negedge clk_i);
    valid_o = 1'b1;
    word_o = w;
    n = -1;
    for (int i = 0; i < 20 && n < 0; i++) begin
      if (ready_i === 1'b1) n = 0;
      else @(negedge clk_i);
    end
    @(negedge clk_i);
    // Released word shows its inverse so nothing stale looks valid
    valid_o = 1'b0;
    word_o = ~w;
    if (n == 0) begin
      n = -1;
      for (int i = 1; i < 20 && n < 0; i++) begin
        if (ready_i === 1'b1) n = i;
        else @(negedge clk_i);
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/mid_decoder_tb.sv */
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module mid_decoder_tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic instr_valid_i, instr_ready_o, pc_load_o, skip_o, sw_reset_o, ind_o;
  logic [13:0] instr_i;
  logic [10:0] pc_target_o, tgt;
  logic [6:0] upper_pc_latch_o;
  logic [7:0] acc_o, option_o;
  mid_pkg::mid_status_t status_o;
  logic [15:0] ptr0_o, ptr1_o;
  logic seen_skip = 1'b0;
  logic seen_pc = 1'b0;
  logic seen_swr = 1'b0;
  int miscompares = 0;
  int n_checks = 0;
  int cyc;
  // 10 MHz core clock
  always #50 clk_i = ~clk_i;
  // Sticky marks, since these outputs stand only a cycle or two
  always @(posedge clk_i) begin
    if (skip_o === 1'b1) seen_skip <= 1'b1;
    if (pc_load_o === 1'b1) seen_pc <= 1'b1;
    if (pc_load_o === 1'b1) tgt <= pc_target_o;
    if (sw_reset_o === 1'b1) seen_swr <= 1'b1;
  end
  mid_decoder DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .instr_ready_o(instr_ready_o), .pc_load_o(pc_load_o),
    .pc_target_o(pc_target_o), .skip_o(skip_o), .upper_pc_latch_o(upper_pc_latch_o),
    .acc_o(acc_o), .status_o(status_o), .option_o(option_o), .ptr0_o(ptr0_o),
    .ptr1_o(ptr1_o), .sw_reset_o(sw_reset_o), .reset_instruction_indicator_o(ind_o));
  mid_fetch_model FETCH (.clk_i(clk_i), .ready_i(instr_ready_o), .valid_o(instr_valid_i),
    .word_o(instr_i));
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // One instruction; a hung handshake ends the run
  task automatic x(input logic [13:0] w);
    {seen_skip, seen_pc, seen_swr} = 3'h0;
    FETCH.issue(w, cyc);
    if (cyc < 0) begin
      miscompares++;
      $display("ERROR handshake exp done got timeout");
      tally_and_finish();
    end
  endtask
  // Carry chain: add then subtract with borrow
  task automatic t_arith();
    x({2'h3, 4'h0, 8'h01});
    x({2'h3, 4'hE, 8'hFF});
    x({2'h3, 4'h0, 8'h0F});
    x({2'h0, 4'h0, 8'hA0});
    x({2'h3, 4'hD, 8'h20});
    `CHK("acc", 8'h1F, acc_o)
    `CHK("status", 3'h2, status_o)
    x({2'h3, 4'h0, 8'h05});
    x({2'h3, 4'hB, 8'h20});
    `CHK("acc", 8'h09, acc_o)
    `CHK("status", 3'h3, status_o)
    x({2'h0, 4'hD, 8'h20});
    `CHK("acc", 8'h1F, acc_o)
    `CHK("status", 3'h2, status_o)
    x({2'h0, 4'hC, 8'h20});
    `CHK("acc", 8'h07, acc_o)
    `CHK("status", 3'h3, status_o)
    $display("arith done");
  endtask
  // Skips: counted byte skips, then every bit test polarity
  task automatic t_skip();
    x({2'h3, 4'h0, 8'h01});
    x({2'h0, 4'h0, 8'hA1});
    x({2'h0, 4'hB, 8'hA1});
    `CHK("skip", 1'b1, seen_skip)
    `CHK("cycles", 3, cyc)
    `CHK("status", 3'h3, status_o)
    x({2'h0, 4'hF, 8'h21});
    `CHK("acc", 8'h01, acc_o)
    `CHK("cycles", 2, cyc)
    for (int i = 0; i < 4; i++) begin
      x({2'h1, i[0] ? 2'h3 : 2'h2, i[1] ? 3'h4 : 3'h3, 7'h20});
      `CHK("skip", i[0] ^ i[1], seen_skip)
      `CHK("cycles", 2 + (i[0] ^ i[1]), cyc)
    end
    x({2'h2, 1'b1, 11'h5A3});
    `CHK("pc load", 1'b1, seen_pc)
    `CHK("target", 11'h5A3, tgt)
    `CHK("cycles", 3, cyc)
    $display("skip done");
  endtask
  // Latch load, literal OR and file XOR flag effects
  task automatic t_logic();
    x({2'h3, 4'h1, 1'b1, 7'h55});
    `CHK("latch", 7'h55, upper_pc_latch_o)
    `CHK("status", 3'h3, status_o)
    x({2'h3, 4'h0, 8'h00});
    x({2'h3, 4'h8, 8'h00});
    `CHK("status", 3'h7, status_o)
    x({2'h3, 4'h8, 8'h80});
    `CHK("acc", 8'h80, acc_o)
    x({2'h3, 4'h0, 8'h0F});
    x({2'h0, 4'h6, 8'hA0});
    `CHK("acc", 8'h0F, acc_o)
    `CHK("status", 3'h7, status_o)
    // New accumulator value; the file byte is now zero, so the XOR result equals it and only the flags show the write
    x({2'h3, 4'h0, 8'h3C});
    x({2'h0, 4'h6, 8'h20});
    `CHK("acc", 8'h3C, acc_o)
    `CHK("status", 3'h3, status_o)
    $display("logic done");
  endtask
  // Indirect stores: wrap, extra cycle of a port read, all modes, relative offset
  task automatic t_ind();
    x({2'h3, 4'h0, 8'h30});
    x({11'h003, 1'b0, 2'h1});
    `CHK("ptr0", 16'hFFFF, ptr0_o)
    `CHK("status", 3'h3, status_o)
    x({2'h0, 4'h8, 8'h00});
    `CHK("acc", 8'h30, acc_o)
    `CHK("cycles", 3, cyc)
    x({11'h003, 1'b0, 2'h2});
    `CHK("ptr0", 16'h0000, ptr0_o)
    for (int m = 0; m < 4; m++) begin
      x({2'h3, 4'h0, 6'h10, m[1:0]});
      x({11'h003, 1'b1, m[1:0]});
      `CHK("ptr1", {15'h0000, ~m[0]}, ptr1_o)
    end
    x({2'h0, 4'h8, 8'h01});
    `CHK("acc", 8'h42, acc_o)
    x({2'h3, 4'h0, 8'h5A});
    x({2'h3, 4'hF, 2'h3, 6'h20});
    `CHK("ptr1", 16'h0000, ptr1_o)
    x({2'h0, 4'h8, 8'h60});
    `CHK("acc", 8'h5A, acc_o)
    $display("indirect done");
  endtask
  // Option load, then software reset
  task automatic t_opt();
    `CHK("indicator", 1'b1, ind_o)
    x({2'h3, 4'h0, 8'h4F});
    x(mid_pkg::WORD_OPTION_LOAD);
    `CHK("option", 8'h4F, option_o)
    `CHK("cycles", 2, cyc)
    x(mid_pkg::WORD_SW_RESET);
    // Pulse stands in the same cycle the handshake returns, gone one cycle later
    `CHK("sw reset", 1'b1, sw_reset_o)
    @(negedge clk_i);
    `CHK("sw pulse", 1'b0, sw_reset_o)
    `CHK("sw seen", 1'b1, seen_swr)
    `CHK("indicator", 1'b0, ind_o)
    `CHK("option", 8'hFF, option_o)
    $display("option done");
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    t_arith();
    t_skip();
    t_logic();
    t_ind();
    t_opt();
    tally_and_finish();
  end
endmodule
`default_nettype wire
